/* design/ddc_top.sv */
/*
 DDR SDRAM command core with base and extended mode registers, bank
 state, refresh counter, DLL state and write-mask gating, plus an
 AXI4-Lite slave for status and control.
 Assumes command pins and write data are synchronous to clk and that the
 controller observes load, burst-terminate and DLL lock spacing.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
// What this block does
// - Load with bank 00 writes base register, 01 extended; opcode from address.
// - Extended register keeps its contents until written again, except that self-refresh exit clears its DLL-disable bit.
// - Extended register controls DLL enable and output drive strength.
// - Leaving self refresh re-enables the DLL with no register write.
// - The unsupported option bits of the extended register have no effect.
// - Deselect and no-op are the same idle cycle.
// - Activate opens the addressed row in the addressed bank.
// - Read and write start a burst at column A0-A9, A11.
// - A10 on read or write selects auto precharge for that command only.
// - Precharge closes one bank, or all banks when A10 is high.
// - Refresh code is auto refresh with CKE high, self refresh with CKE low.
// - Refresh rows come from an internal counter; other inputs are ignored.
// - A write element is stored when its mask is low, dropped when high.
// - Base load with A8 set pulses DLL reset; A8 is not stored.
`timescale 1ns/1ps
`default_nettype none
module ddc_top import ddc_pkg::*; #(
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wdata_valid,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic dm,
    output logic act_q,
    output logic rd_q,
    output logic wr_q,
    output logic bst_q,
    output logic pre_q,
    output logic aref_q,
    output logic [BA_W-1:0] cmd_bank_q,
    output logic [ADDR_W-1:0] cmd_row_q,
    output logic [COL_W-1:0] cmd_col_q,
    output logic auto_pre_q,
    output logic [NBANK-1:0] pre_mask_q,
    output logic [NBANK-1:0] bank_open_q,
    output logic [ADDR_W-1:0] ref_row_q,
    output logic self_ref_q,
    output logic dll_on_q,
    output logic dll_reset_q,
    output logic dll_ready_q,
    output logic drive_reduced_q,
    output logic mem_we_q,
    output logic [DATA_W-1:0] mem_wdata_q,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    ddc_cmd_if cmd_bus ();
    logic ctrl_en_q;
    logic decode_en;

    // Inputs other than clock enable are ignored in self refresh
    assign decode_en = ctrl_en_q && !self_ref_q;

    ddc_decode u_decode (
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .cke(cke),
        .decode_en(decode_en),
        .ba(ba),
        .addr(addr),
        .cmd_o(cmd_bus.dec)
    );

    // ------------------------------------------------------------------
    // Command strobes and named fields
    // ------------------------------------------------------------------
    ddc_cmd_e cmd;
    logic is_act, is_rd, is_wr, is_pre, is_aref, is_sref, is_mrs, is_emrs;
    logic a10;
    logic sref_exit;
    logic [NBANK-1:0] bank_onehot;
    logic [COL_W-1:0] col;

    assign cmd = cmd_bus.cmd;
    assign is_act = (cmd == CMD_ACT);
    assign is_rd = (cmd == CMD_RD);
    assign is_wr = (cmd == CMD_WR);
    assign is_pre = (cmd == CMD_PRE);
    assign is_aref = (cmd == CMD_AREF);
    assign is_sref = (cmd == CMD_SREF);
    assign is_mrs = (cmd == CMD_MRS);
    assign is_emrs = (cmd == CMD_EMRS);
    assign a10 = cmd_bus.addr[A10_POS];
    assign bank_onehot = NBANK'(1) << cmd_bus.ba;
    // Column skips A10, which carries the precharge option
    assign col = {cmd_bus.addr[A11_POS], cmd_bus.addr[COL_LO_W-1:0]};

    // ------------------------------------------------------------------
    // Power state: running or self refresh
    // ------------------------------------------------------------------
    ddc_pwr_e pwr_q, pwr_d;

    // Self refresh holds until clock enable returns high
    always_comb begin
        case (pwr_q)
            PWR_RUN: pwr_d = is_sref ? PWR_SELF : PWR_RUN;
            PWR_SELF: pwr_d = cke ? PWR_RUN : PWR_SELF;
            default: pwr_d = PWR_RUN;
        endcase
    end
    assign sref_exit = (pwr_q == PWR_SELF) && cke;

    always_ff @(posedge clk) begin
        if (reset) begin
            pwr_q <= PWR_RUN;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // ------------------------------------------------------------------
    // Mode registers and DLL
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] bmr_q, emr_q, emr_d;
    logic [DLL_CNT_W-1:0] dll_cnt_q;
    logic dll_start;

    // Self-refresh exit clears the DLL-disable bit by itself
    assign emr_d = is_emrs ? cmd_bus.addr :
                   sref_exit ? (emr_q & ~EMR_DLL_DIS_MASK) : emr_q;
    // A fresh enable or a DLL reset restarts the lock count
    assign dll_start = (!emr_d[EMR_DLL_DIS_POS] && !dll_on_q) ||
                       (is_mrs && cmd_bus.addr[A8_POS]);

    // Base register load; the DLL reset bit is never stored
    always_ff @(posedge clk) begin
        if (reset) begin
            bmr_q <= MR_RESET;
            emr_q <= MR_RESET;
        end else begin
            if (is_mrs) begin
                bmr_q <= cmd_bus.addr & ~MR_DLL_RST_MASK;
            end
            emr_q <= emr_d;
        end
    end

    // Only bits 0 and 1 act; other stored bits have no function
    always_ff @(posedge clk) begin
        if (reset) begin
            dll_on_q <= 1'b1;
            drive_reduced_q <= 1'b0;
            dll_reset_q <= 1'b0;
        end else begin
            dll_on_q <= !emr_d[EMR_DLL_DIS_POS];
            drive_reduced_q <= emr_d[EMR_DRV_RED_POS];
            dll_reset_q <= is_mrs && cmd_bus.addr[A8_POS];
        end
    end

    // Lock counter; status only, reads are not blocked by it
    always_ff @(posedge clk) begin
        if (reset) begin
            dll_cnt_q <= '0;
            dll_ready_q <= 1'b0;
        end else if (emr_d[EMR_DLL_DIS_POS] || dll_start) begin
            dll_cnt_q <= '0;
            dll_ready_q <= 1'b0;
        end else if (!dll_ready_q) begin
            dll_cnt_q <= dll_cnt_q + DLL_CNT_W'(1);
            dll_ready_q <= (dll_cnt_q == DLL_CNT_W'(DLL_LOCK_CYCLES - 1));
        end
    end

    // ------------------------------------------------------------------
    // Bank state and command outputs
    // ------------------------------------------------------------------
    logic [NBANK-1:0] close_mask;

    // Precharge with A10 high ignores the bank bits
    assign close_mask = is_pre ? (a10 ? {NBANK{1'b1}} : bank_onehot) :
                        ((is_rd || is_wr) && a10) ? bank_onehot : '0;

    always_ff @(posedge clk) begin
        if (reset) begin
            bank_open_q <= '0;
        end else begin
            bank_open_q <= (bank_open_q & ~close_mask) |
                           (is_act ? bank_onehot : '0);
        end
    end

    // One-cycle strobes for activate, read, write, burst terminate, precharge and auto refresh
    always_ff @(posedge clk) begin
        if (reset) begin
            act_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            bst_q <= 1'b0;
            pre_q <= 1'b0;
            aref_q <= 1'b0;
        end else begin
            act_q <= is_act;
            rd_q <= is_rd;
            wr_q <= is_wr;
            bst_q <= (cmd == CMD_BST);
            pre_q <= is_pre;
            aref_q <= is_aref;
        end
    end

    // Fields held until the next command of their kind
    always_ff @(posedge clk) begin
        if (reset) begin
            cmd_bank_q <= '0;
            cmd_row_q <= '0;
            cmd_col_q <= '0;
            auto_pre_q <= 1'b0;
            pre_mask_q <= '0;
        end else begin
            if (is_act || is_rd || is_wr || is_pre) begin
                cmd_bank_q <= cmd_bus.ba;
            end
            if (is_act) begin
                cmd_row_q <= cmd_bus.addr;
            end
            if (is_rd || is_wr) begin
                cmd_col_q <= col;
                auto_pre_q <= a10;
            end
            if (is_pre) begin
                pre_mask_q <= close_mask;
            end
        end
    end

    // ------------------------------------------------------------------
    // Refresh counter and self-refresh flag
    // ------------------------------------------------------------------
    // Rows come only from the counter, never from the address pins
    always_ff @(posedge clk) begin
        if (reset) begin
            ref_row_q <= '0;
            self_ref_q <= 1'b0;
        end else begin
            if (is_aref || is_sref) begin
                ref_row_q <= ref_row_q + ADDR_W'(1);
            end
            self_ref_q <= (pwr_d == PWR_SELF);
        end
    end

    // ------------------------------------------------------------------
    // Write data masking
    // ------------------------------------------------------------------
    // Masked elements never reach the array
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_we_q <= 1'b0;
            mem_wdata_q <= '0;
        end else begin
            mem_we_q <= wdata_valid && !dm;
            mem_wdata_q <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic aw_got_q, w_got_q;
    logic [AXI_AW-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_write;
    logic [AXI_AW-1:0] waligned, raligned;
    logic wmapped, rmapped;
    logic [31:0] status_word, rd_word;

    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    assign waligned = {waddr_q[AXI_AW-1:2], 2'h0};
    assign raligned = {s_axi_araddr[AXI_AW-1:2], 2'h0};
    assign wmapped = (waligned <= OFS_REFCNT);
    assign rmapped = (raligned <= OFS_REFCNT);
    assign status_word = {24'h0, dll_ready_q, dll_on_q, drive_reduced_q,
                          self_ref_q, bank_open_q};
    // Read mux; unmapped words read zero
    assign rd_word = (raligned == OFS_CTRL) ? {31'h0, ctrl_en_q} :
                     (raligned == OFS_STATUS) ? status_word :
                     (raligned == OFS_BMR) ? {19'h0, bmr_q} :
                     (raligned == OFS_EMR) ? {19'h0, emr_q} :
                     (raligned == OFS_REFCNT) ? {19'h0, ref_row_q} : 32'h0;

    // Address and data taken in either order, answered after both
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                s_axi_awready <= 1'b0;
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Write answer and the one writable bit
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl_en_q <= CTRL_EN_RESET;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wmapped ? RESP_OKAY : RESP_SLVERR;
            if (waligned == OFS_CTRL && wstrb_q[0]) begin
                ctrl_en_q <= wdata_q[0];
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rmapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking dcb @(posedge clk); endclocking
    default disable iff (reset);

    emr_load_a: assert property (is_emrs |=> emr_q == $past(cmd_bus.addr))
        else $error("extended register load lost");
    emr_hold_a: assert property (!is_emrs && !sref_exit |=> $stable(emr_q))
        else $error("extended register changed without load");
    dll_ctl_a: assert property (is_emrs && !self_ref_q |=>
        dll_on_q == !$past(cmd_bus.addr[EMR_DLL_DIS_POS]) &&
        drive_reduced_q == $past(cmd_bus.addr[EMR_DRV_RED_POS]))
        else $error("DLL or drive setting wrong after load");
    sref_dll_a: assert property (sref_exit |=> dll_on_q && !self_ref_q)
        else $error("DLL not enabled on self refresh exit");
    dll_lock_a: assert property ($rose(dll_on_q) |-> !dll_ready_q [*8])
        else $error("DLL ready too early");
    nop_idle_a: assert property (cmd == CMD_NOP |=>
        !(act_q || rd_q || wr_q || pre_q || aref_q) && $stable(bank_open_q))
        else $error("idle cycle caused an action");
    act_row_a: assert property (is_act |=> act_q && cmd_row_q == $past(cmd_bus.addr)
        && bank_open_q[cmd_bank_q])
        else $error("activate did not open row");
    rd_col_a: assert property (is_rd |=> rd_q && cmd_col_q == $past(col)
        && auto_pre_q == $past(a10))
        else $error("read column or precharge option wrong");
    pre_all_a: assert property (is_pre && a10 |=> pre_mask_q == {NBANK{1'b1}}
        && bank_open_q == '0)
        else $error("precharge all left a bank open");
    sref_hold_a: assert property (self_ref_q && !cke |-> cmd == CMD_NOP)
        else $error("command taken in self refresh");
    dm_mask_a: assert property (wdata_valid && dm |=> !mem_we_q)
        else $error("masked element written");
    dll_rst_a: assert property (is_mrs && cmd_bus.addr[A8_POS] |=>
        dll_reset_q && !bmr_q[A8_POS] ##1 !dll_reset_q)
        else $error("DLL reset bit stored or not pulsed");

    act_seen_c: cover property (is_act ##[1:20] is_rd);
    sref_trip_c: cover property (is_sref ##[1:50] sref_exit);
    emr_load_c: cover property (is_emrs ##1 !dll_on_q);
    mask_write_c: cover property (wdata_valid && !dm ##1 wdata_valid && dm);
endmodule
`default_nettype wire

/* shared/ddc_pkg.sv */
/*
 Shared constants and types for the DDR command decoder and its extended
 mode register: address layout, option bit positions, register offsets,
 command and power-state encodings.
 Assumes nothing of its surroundings; imported whole by every design file.
*/
package ddc_pkg;
    // ------------------------------------------------------------------
    // Pin and field layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int NBANK = 4;
    localparam int COL_W = 11;
    localparam int COL_LO_W = 10;
    localparam int A10_POS = 10;
    localparam int A11_POS = 11;
    localparam int A8_POS = 8;
    localparam int EMR_DLL_DIS_POS = 0;
    localparam int EMR_DRV_RED_POS = 1;
    localparam logic [1:0] BA_SEL_BMR = 2'h0;
    localparam logic [1:0] BA_SEL_EMR = 2'h1;
    localparam logic [12:0] MR_RESET = 13'h0000;
    localparam logic [12:0] MR_DLL_RST_MASK = 13'h0100;
    localparam logic [12:0] EMR_DLL_DIS_MASK = 13'h0001;
    // Clock cycles from DLL enable until a read may be issued
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int DLL_CNT_W = 8;
    // ------------------------------------------------------------------
    // AXI4-Lite register map
    // ------------------------------------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BMR = 8'h08;
    localparam logic [7:0] OFS_EMR = 8'h0c;
    localparam logic [7:0] OFS_REFCNT = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic CTRL_EN_RESET = 1'b1;
    // ------------------------------------------------------------------
    // Commands and power states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
        CMD_BST = 4'h4, CMD_PRE = 4'h5, CMD_AREF = 4'h6, CMD_SREF = 4'h7,
        CMD_MRS = 4'h8, CMD_EMRS = 4'h9, CMD_RSVD = 4'ha
    } ddc_cmd_e;
    typedef enum logic [0:0] {PWR_RUN = 1'h0, PWR_SELF = 1'h1} ddc_pwr_e;
endpackage

/* shared/ddc_cmd_if.sv */
/*
 Carries one decoded command with its bank and address from the pin
 decoder to the command core.
 Assumes both ends run on the same clock; the content is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface ddc_cmd_if import ddc_pkg::*; ();
    ddc_cmd_e cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    modport dec (output cmd, output ba, output addr);
    modport core (input cmd, input ba, input addr);
endinterface
`default_nettype wire

/* design/ddc_decode.sv */
/*
 Pin-level command decoder: turns chip select, row/column strobes, write
 enable and clock enable into one command per clock.
 Assumes pins are synchronous to clk; output is combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_decode import ddc_pkg::*; (
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic decode_en,
    input wire logic [BA_W-1:0] ba,
    input wire logic [ADDR_W-1:0] addr,
    ddc_cmd_if.dec cmd_o
);
    // ------------------------------------------------------------------
    // Command table
    // ------------------------------------------------------------------
    logic register_select_high_bit;
    logic register_select_low_bit;
    logic [1:0] mr_sel;
    ddc_cmd_e cmd_raw;
    ddc_cmd_e cmd_lmr;

    assign register_select_high_bit = ba[1];
    assign register_select_low_bit = ba[0];
    assign mr_sel = {register_select_high_bit, register_select_low_bit};
    // Other bank codes on a load are reserved and do nothing
    assign cmd_lmr = (mr_sel == BA_SEL_BMR) ? CMD_MRS :
                     (mr_sel == BA_SEL_EMR) ? CMD_EMRS : CMD_RSVD;

    // Deselect and no-op collapse to one code
    always_comb begin
        case ({ras_n, cas_n, we_n})
            3'h3: cmd_raw = CMD_ACT;
            3'h5: cmd_raw = CMD_RD;
            3'h4: cmd_raw = CMD_WR;
            3'h6: cmd_raw = CMD_BST;
            3'h2: cmd_raw = CMD_PRE;
            3'h1: cmd_raw = cke ? CMD_AREF : CMD_SREF;
            3'h0: cmd_raw = cmd_lmr;
            default: cmd_raw = CMD_NOP;
        endcase
    end

    // Only the refresh code may be taken with clock enable low
    assign cmd_o.cmd = (cs_n || !decode_en) ? CMD_NOP :
                       (!cke && cmd_raw != CMD_SREF) ? CMD_NOP : cmd_raw;
    assign cmd_o.ba = ba;
    assign cmd_o.addr = addr;
endmodule
`default_nettype wire

/* testbench/ddc_ctrl_model.sv */
/*
 Memory-controller model driving the command pins of the decoder.
 Assumes the bench calls issue() and that clk is the device clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_ctrl_model import ddc_pkg::*; (
    input wire logic clk,
    input wire logic reset,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic cke,
    output logic [BA_W-1:0] ba,
    output logic [ADDR_W-1:0] addr
);
    int lock_cnt = 0;
    logic cke_q = 1'b1;
    initial {cs_n, ras_n, cas_n, we_n, cke, ba, addr} = 20'hfffff;
    // Cycles since reset or self-refresh exit; one process owns the count so
    // a restart cannot race the increment
    always @(posedge clk) begin
        cke_q <= cke;
        lock_cnt <= (reset || (cke && !cke_q)) ? 0 : lock_cnt + 1;
    end
    // One command for one cycle; idle deselects with a scrambled address so
    // stale values never look valid
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
        input logic k);
        @(posedge clk);
        while (c == 4'h5 && lock_cnt < DLL_LOCK_CYCLES) @(posedge clk);
        {cs_n, ras_n, cas_n, we_n, ba, addr, cke} <= {c, b, a, k};
        @(posedge clk);
        {cs_n, addr} <= {1'b1, ~a};
    endtask
endmodule
`default_nettype wire

/* testbench/ddr_sdram_command_decode_emr_bench.sv */
/*
 Self-checking bench for the command decoder and its mode registers.
 Assumes ddc_top with default width and the controller model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_sdram_command_decode_emr_bench import ddc_pkg::*; ;
    logic clk = 0, reset = 1, wdata_valid = 0, dm = 0;
    logic [7:0] wdata = 0, s_axi_awaddr = 0, s_axi_araddr = 0, mem_wdata_q;
    logic cs_n, ras_n, cas_n, we_n, cke, act_q, rd_q, auto_pre_q, self_ref_q, dll_on_q;
    logic dll_reset_q, drive_reduced_q, mem_we_q, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
    logic wr_q, bst_q, pre_q, aref_q, dll_ready_q;
    logic [1:0] ba, b, r, cmd_bank_q, s_axi_bresp, s_axi_rresp;
    logic [3:0] pre_mask_q, bank_open_q;
    logic [10:0] cmd_col_q;
    logic [12:0] addr, a, cmd_row_q, ref_row_q;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    int err_count = 0, tests_run = 0;
    always #4 clk = ~clk;
    ddc_ctrl_model ctl_u (.clk, .reset, .cs_n, .ras_n, .cas_n, .we_n, .cke, .ba, .addr);
    ddc_top dut_u (.clk, .reset, .cs_n, .ras_n, .cas_n, .we_n, .cke, .ba, .addr, .wdata_valid,
        .wdata, .dm, .act_q, .rd_q, .wr_q, .bst_q, .pre_q, .aref_q, .cmd_bank_q,
        .cmd_row_q, .cmd_col_q, .auto_pre_q, .pre_mask_q, .bank_open_q, .ref_row_q, .self_ref_q,
        .dll_on_q, .dll_reset_q, .dll_ready_q, .drive_reduced_q, .mem_we_q, .mem_wdata_q,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded bus waits; a stuck slave counts as a mismatch
    task automatic axw(input logic [7:0] ad, input logic [31:0] wd, output logic [1:0] rs);
        int i;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, wd, 3'h7};
        for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
            @(posedge clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 0;
        if (i == 50) begin err_count++; end_of_test; end
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] rd, output logic [1:0] rs);
        int i;
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
        for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
            @(posedge clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
        end
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
        if (i == 50) begin err_count++; end_of_test; end
    endtask
    // Hang guard
    initial begin repeat (5000) @(posedge clk); err_count++; end_of_test; end
    // Main sequence
    initial begin
        void'($urandom(32'ha9c8c50c));
        repeat (3) @(posedge clk);
        reset <= 0;
        a = $urandom;
        b = $urandom;
        ctl_u.issue(4'h3, b, a, 1);
        #1 chk({act_q, cmd_bank_q, cmd_row_q, bank_open_q}, {1'b1, b, a, 4'h1 << b});
        a[10] = 1;
        ctl_u.issue(4'h5, b, a, 1);
        #1 chk({rd_q, cmd_col_q}, {1'b1, a[11], a[9:0]});
        chk({auto_pre_q, bank_open_q}, 5'h10);
        chk(dll_ready_q, 1);
        ctl_u.issue(4'h3, b, a, 1);
        ctl_u.issue(4'h5, b, 13'h0000, 1);
        #1 chk({auto_pre_q, bank_open_q}, {1'b0, 4'h1 << b});
        ctl_u.issue(4'h6, 0, 0, 1);
        #1 chk(bst_q, 1);
        ctl_u.issue(4'h2, b, 13'h0000, 1);
        #1 chk({pre_q, pre_mask_q, bank_open_q}, {1'b1, 4'h1 << b, 4'h0});
        ctl_u.issue(4'h3, ~b, a, 1);
        ctl_u.issue(4'h4, ~b, a, 1);
        #1 chk({wr_q, cmd_col_q}, {1'b1, a[11], a[9:0]});
        chk({auto_pre_q, bank_open_q}, 5'h10);
        ctl_u.issue(4'h2, b, 13'h0400, 1);
        #1 chk({pre_mask_q, bank_open_q}, 8'hf0);
        ctl_u.issue(4'h7, b, a, 1);
        ctl_u.issue(4'hb, b, a, 1);
        #1 chk({act_q, bank_open_q}, 0);
        $display("bank commands done");
        ctl_u.issue(4'h0, 2'h1, 13'h0003, 1);
        #1 chk({dll_on_q, drive_reduced_q}, 2'h1);
        ctl_u.issue(4'h0, 2'h3, 13'h0000, 1);
        axr(OFS_EMR, d, r);
        chk({d, dll_on_q, drive_reduced_q}, {32'h3, 2'h1});
        ctl_u.issue(4'h1, 0, 0, 1);
        #1 chk({aref_q, ref_row_q}, {1'b1, 13'h1});
        ctl_u.issue(4'h1, 0, a, 0);
        ctl_u.issue(4'h3, b, a, 0);
        #1 chk({self_ref_q, act_q, ref_row_q}, {2'h2, 13'h2});
        ctl_u.issue(4'hf, 0, 0, 1);
        #1 chk({self_ref_q, dll_on_q, dll_ready_q}, 3'h2);
        ctl_u.issue(4'h0, 2'h0, 13'h0132, 1);
        #1 chk(dll_reset_q, 1);
        axr(OFS_BMR, d, r);
        chk(d, 32'h32);
        $display("mode and refresh done");
        d = $urandom;
        @(posedge clk) {wdata_valid, dm, wdata} <= {2'h2, d[7:0]};
        @(posedge clk) dm <= 1;
        #1 chk({mem_we_q, mem_wdata_q}, {1'b1, d[7:0]});
        @(posedge clk) wdata_valid <= 0;
        #1 chk(mem_we_q, 0);
        axw(OFS_CTRL, 0, r);
        ctl_u.issue(4'h3, b, a, 1);
        #1 chk({r, act_q}, 3'h0);
        axw(OFS_CTRL, 1, r);
        axr(8'h20, d, r);
        chk(r, RESP_SLVERR);
        $display("data and bus done");
        end_of_test;
    end
endmodule
`default_nettype wire
